// *** lds_consts.svh ***
// Timing counts and encodings for the LED driver start-up sequencer
`ifndef LDS_CONSTS_SVH
`define LDS_CONSTS_SVH
`define LDS_CLK_MHZ          20
`define LDS_FIRST_ON_MIN_NS  750
`define LDS_FIRST_ON_CYC     ((`LDS_FIRST_ON_MIN_NS*`LDS_CLK_MHZ+999)/1000)
`define LDS_SYNC_LOSS_US     7
`define LDS_SYNC_LOSS_CYC    (`LDS_SYNC_LOSS_US*`LDS_CLK_MHZ)
// Low this long is no legal sync phase; shorter lows must not pause
`define LDS_SYNC_GAP_CYC     40
`define LDS_FREQ_SET_PIN_REL_US      5
`define LDS_FREQ_SET_PIN_REL_CYC     (`LDS_FREQ_SET_PIN_REL_US*`LDS_CLK_MHZ)
`define LDS_SHDN_MS          65
`define LDS_SHDN_CYC         (`LDS_SHDN_MS*1000*`LDS_CLK_MHZ)
`define LDS_DET_MIN_SW       3000
`define LDS_DET_SW           3500
`define LDS_DIM_LOW_SW       32750
`define LDS_NCH              2
`define LDS_CLS_SHORT        2'h0
`define LDS_CLS_UNUSED       2'h1
`define LDS_CLS_INUSE        2'h2
`define LDS_SW_MAX_MHZ_X10   35
`endif

// *** lds_host_model.sv ***
// Host controller model driving the enable/dimming and sync pins
`include "lds_consts.svh"
module lds_host_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Commands from the bench
    input  wire logic       en_req,
    input  wire logic       sync_run,
    input  wire logic [3:0] sync_half,
    // Pins toward the device
    output logic            en_dim_pin,
    output logic            sync_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hold_ff;
    logic [3:0] ph_ff;
    wire  [3:0] half_len = (sync_half < 4'h3) ? 4'h3 : sync_half;

    // A high pulse is never cut below the minimum on-time
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en_dim_pin <= 1'b0;
            hold_ff    <= 8'h00;
        end else if (en_req && !en_dim_pin) begin
            en_dim_pin <= 1'b1;
            hold_ff    <= 8'(`LDS_FIRST_ON_CYC);
        end else if (hold_ff != 8'h00) begin
            hold_ff <= hold_ff - 8'h01;
        end else begin
            en_dim_pin <= en_req;
        end
    end

    // Stopped clock rests low, which the device reads as a lost sync
    always_ff @(posedge core_clk) begin
        if (sys_rst || !sync_run) begin
            sync_pin <= 1'b0;
            ph_ff    <= 4'h0;
        end else if (ph_ff + 4'h1 >= half_len) begin
            sync_pin <= ~sync_pin;
            ph_ff    <= 4'h0;
        end else begin
            ph_ff <= ph_ff + 4'h1;
        end
    end
endmodule

// *** lds_pkg.sv ***
// Types for the LED driver start-up sequencer
package lds_pkg;
    typedef enum logic [2:0] {
        LDS_OFF, LDS_WAIT_FREQ, LDS_GATE_RAMP, LDS_DETECT,
        LDS_SHORT_HOLD, LDS_SOFT_START, LDS_RUN, LDS_SHUTDOWN
    } lds_state_e;
endpackage

// *** lds_sequencer.sv ***
// LED driver start-up, sync and shutdown sequencer
`include "lds_consts.svh"
module lds_sequencer (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    // Host side pins
    input  wire logic                      en_dim_pin,
    input  wire logic                      sync_pin,
    // Analog comparator levels
    input  wire logic                      undervoltage_lockout,
    input  wire logic                      freq_set_pin,
    input  wire logic                      freq_clamp_req,
    input  wire logic                      gate_ready,
    input  wire logic [`LDS_NCH-1:0]       led_above_120mv,
    input  wire logic [`LDS_NCH-1:0]       led_below_70mv,
    input  wire logic [`LDS_NCH-1:0]       led_above_325mv,
    input  wire logic                      led_voltage_ok,
    input  wire logic                      osc_tick,
    // Outputs to the power stage
    output logic                           disconnect_on,
    output logic                           boost_enable,
    output logic [`LDS_NCH-1:0]            sink_enable,
    output logic [`LDS_NCH-1:0]            channel_in_loop,
    output logic                           softstart_sink_current,
    output logic                           softstart_switch_limit,
    output logic                           full_switch_limit,
    output logic                           use_sync_clock,
    output logic                           freq_clamp,
    output logic                           low_power,
    output lds_pkg::lds_state_e            state
);
    import lds_pkg::*;

    localparam logic [22:0] FIRST_ON = 23'(`LDS_FIRST_ON_CYC);
    localparam logic [22:0] SYNC_LOSS = 23'(`LDS_SYNC_LOSS_CYC);
    localparam logic [22:0] FREQ_SET_PIN_REL = 23'(`LDS_FREQ_SET_PIN_REL_CYC);
    localparam logic [22:0] SHDN = 23'(`LDS_SHDN_CYC);
    localparam logic [15:0] DET_SW = 16'(`LDS_DET_SW);
    localparam logic [15:0] DIM_SW = 16'(`LDS_DIM_LOW_SW);
    localparam logic [22:0] SYNC_GAP = 23'(`LDS_SYNC_GAP_CYC);

    // Pin synchronisers
    logic [1:0] en_s1_ff, sy_s1_ff, fs_s1_ff;
    logic       sync_prev_ff;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en_s1_ff <= 2'h0;
            sy_s1_ff <= 2'h0;
            fs_s1_ff <= 2'h0;
        end else begin
            en_s1_ff <= {en_s1_ff[0], en_dim_pin};
            sy_s1_ff <= {sy_s1_ff[0], sync_pin};
            fs_s1_ff <= {fs_s1_ff[0], freq_set_pin};
        end
    end
    wire en_s   = en_s1_ff[1];
    wire sync_s = sy_s1_ff[1];
    wire freq_set_pin_s = fs_s1_ff[1];

    // Sync clock detection and loss timing
    logic [22:0] sync_low_ff, en_high_ff, en_low_ff, shd_time_ff;
    logic [15:0] sw_low_ff, det_cnt_ff;
    logic        sync_det_ff, lose_pause_ff;
    logic [1:0]  cls_short_ff, cls_used_ff;
    lds_state_e  st_ff, nxt_st;
    wire sync_rise = sync_s & ~sync_prev_ff;
    wire sync_lost = sync_low_ff >= SYNC_LOSS;
    // Selected switching clock: sync edges or oscillator ticks
    wire sw_tick = sync_det_ff ? sync_rise : osc_tick;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync_prev_ff <= 1'b0;
            sync_low_ff  <= 23'h0;
            sync_det_ff  <= 1'b0;
        end else begin
            sync_prev_ff <= sync_s;
            sync_low_ff  <= sync_s ? 23'h0
                          : (sync_lost ? sync_low_ff : sync_low_ff + 23'h1);
            // Edge enables sync, extended low reverts to oscillator
            if (sync_rise)
                sync_det_ff <= 1'b1;
            else if (sync_lost)
                sync_det_ff <= 1'b0;
        end
    end

    // Enable pin timers
    wire first_on_ok = en_high_ff >= FIRST_ON;
    wire shdn_due    = en_low_ff >= SHDN;
    wire dim_due     = sw_low_ff >= DIM_SW;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en_high_ff <= 23'h0;
            en_low_ff  <= 23'h0;
            sw_low_ff  <= 16'h0;
        end else begin
            en_high_ff <= !en_s ? 23'h0
                        : (first_on_ok ? en_high_ff : en_high_ff + 23'h1);
            en_low_ff  <= en_s ? 23'h0
                        : (shdn_due ? en_low_ff : en_low_ff + 23'h1);
            sw_low_ff  <= en_s ? 16'h0
                        : ((dim_due || !sw_tick) ? sw_low_ff
                           : sw_low_ff + 16'h1);
        end
    end

    // Per-channel classification at the end of detection
    wire det_done = det_cnt_ff >= DET_SW;
    // Each pin has settled: risen past 120 mV or held down by a short
    wire det_armed = &(led_above_120mv | led_below_70mv);
    genvar g;
    generate
        for (g = 0; g < `LDS_NCH; g++) begin : g_ch
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    cls_short_ff[g] <= 1'b0;
                    cls_used_ff[g]  <= 1'b0;
                end else if (st_ff == LDS_DETECT && det_done) begin
                    cls_short_ff[g] <= led_below_70mv[g];
                    cls_used_ff[g]  <= led_above_325mv[g];
                end
            end
        end
    endgenerate

    // Detection delay counter on the selected switching clock
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            det_cnt_ff <= 16'h0;
        else if (st_ff != LDS_DETECT || !det_armed)
            det_cnt_ff <= 16'h0;
        else if (st_ff == LDS_DETECT && sw_tick && !det_done)
            det_cnt_ff <= det_cnt_ff + 16'h1;
    end

    // Time spent in shutdown, whether entered on sync loss, freq pin short or dimming
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            shd_time_ff <= 23'h0;
        else if (st_ff != LDS_SHUTDOWN)
            shd_time_ff <= 23'h0;
        else if (shd_time_ff < FREQ_SET_PIN_REL)
            shd_time_ff <= shd_time_ff + 23'h1;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            lose_pause_ff <= 1'b0;
        else
            // Only a missing clock pauses; normal low phases keep switching
            lose_pause_ff <= sync_det_ff
                             & (sync_low_ff >= SYNC_GAP);
    end

    wire freq_src_ok = freq_set_pin_s | sync_det_ff;
    wire start_ok    = en_s & first_on_ok & ~undervoltage_lockout;
    wire freq_set_pin_short  = ~freq_set_pin_s & ~sync_det_ff & ~sync_s;

    // Sequencer
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            LDS_OFF: begin
                if (start_ok)
                    nxt_st = LDS_WAIT_FREQ;
            end
            LDS_WAIT_FREQ: begin
                if (undervoltage_lockout || !en_s)
                    nxt_st = LDS_OFF;
                else if (freq_src_ok)
                    nxt_st = LDS_GATE_RAMP;
            end
            LDS_GATE_RAMP: begin
                if (gate_ready)
                    nxt_st = LDS_DETECT;
            end
            LDS_DETECT: begin
                // Detection is the system check ahead of LED current
                if (det_done)
                    nxt_st = (|led_below_70mv) ? LDS_SHORT_HOLD
                                               : LDS_SOFT_START;
            end
            LDS_SHORT_HOLD: begin
                if (!(|led_below_70mv))
                    nxt_st = LDS_DETECT;
            end
            LDS_SOFT_START: begin
                if (led_voltage_ok)
                    nxt_st = LDS_RUN;
            end
            LDS_RUN: begin
                if (sync_lost && sync_det_ff || freq_set_pin_short && sync_lost)
                    nxt_st = LDS_SHUTDOWN;
                else if (!en_s && dim_due)
                    nxt_st = LDS_SHUTDOWN;
            end
            LDS_SHUTDOWN: begin
                if (shdn_due)
                    nxt_st = LDS_OFF;
                else if (freq_set_pin_s && shd_time_ff >= FREQ_SET_PIN_REL && en_s)
                    nxt_st = LDS_SOFT_START;
            end
            default: nxt_st = LDS_OFF;
        endcase
        if (undervoltage_lockout)
            nxt_st = LDS_OFF;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            st_ff <= LDS_OFF;
        else
            st_ff <= nxt_st;
    end

    // Registered outputs
    wire in_ss  = st_ff == LDS_SOFT_START;
    wire in_run = st_ff == LDS_RUN;
    wire active = in_ss | in_run;
    wire [1:0] used = cls_used_ff & ~cls_short_ff;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            disconnect_on          <= 1'b0;
            boost_enable           <= 1'b0;
            sink_enable            <= 2'h0;
            channel_in_loop        <= 2'h0;
            softstart_sink_current <= 1'b0;
            softstart_switch_limit <= 1'b0;
            full_switch_limit      <= 1'b0;
            use_sync_clock         <= 1'b0;
            freq_clamp             <= 1'b0;
            low_power              <= 1'b1;
            state                  <= LDS_OFF;
        end else begin
            disconnect_on <= st_ff inside {LDS_GATE_RAMP, LDS_DETECT,
                LDS_SHORT_HOLD, LDS_SOFT_START, LDS_RUN};
            // Dimming low keeps references alive; it stops power stage in run, not in soft start
            boost_enable  <= active & (en_s | in_ss)
                             & ~lose_pause_ff;
            sink_enable   <= (active & (en_s | in_ss)) ? used
                                                       : 2'h0;
            channel_in_loop        <= used;
            softstart_sink_current <= in_ss;
            softstart_switch_limit <= in_ss;
            full_switch_limit      <= in_run;
            use_sync_clock         <= sync_det_ff;
            // Resistor range is analog; only the fault clamp is logic
            freq_clamp    <= freq_clamp_req & active;
            low_power     <= st_ff == LDS_OFF;
            state         <= st_ff;
        end
    end

    // Assertions
    AST_SS_LIMIT: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(softstart_switch_limit) |-> !full_switch_limit)
        else $error("soft start limit overlaps full limit");
    AST_RUN_FULL: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_ff == LDS_RUN |=> full_switch_limit)
        else $error("run without full limit");
    AST_NO_SINK_PRE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (st_ff inside {LDS_DETECT, LDS_SHORT_HOLD}) |=> sink_enable == 2'h0)
        else $error("sinks on before check");
    AST_SHORT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_ff == LDS_SHORT_HOLD && |led_below_70mv && !undervoltage_lockout
        |=> st_ff == LDS_SHORT_HOLD)
        else $error("left hold with short");
    AST_GATE: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(st_ff == LDS_DETECT) |-> $past(gate_ready) || $past(st_ff)
        == LDS_SHORT_HOLD)
        else $error("detect before gate ready");
    AST_DET_MIN: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_ff == LDS_DETECT && nxt_st != LDS_DETECT && !undervoltage_lockout
        |-> det_cnt_ff >= 16'(`LDS_DET_MIN_SW))
        else $error("detection too short");
    AST_UNUSED: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sink_enable & ~channel_in_loop) == 2'h0)
        else $error("unused channel sinking");
    AST_SHDN_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_ff == LDS_SHUTDOWN |=> !boost_enable && !disconnect_on
        && sink_enable == 2'h0)
        else $error("shutdown still driving");
    AST_FREQ_WAIT: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_ff == LDS_WAIT_FREQ && !freq_src_ok |=> st_ff != LDS_GATE_RAMP)
        else $error("start without frequency source");
    AST_START: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_ff == LDS_OFF && nxt_st == LDS_WAIT_FREQ |-> first_on_ok)
        else $error("start without first pulse");
endmodule

// *** tb_lds_sequencer.sv ***
// Self-checking bench for the start-up sequencer
`include "lds_consts.svh"
module tb_lds_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import lds_pkg::*;
    logic                core_clk;
    logic                sys_rst;
    logic                en_req;
    logic                sync_run;
    logic [3:0]          sync_half;
    logic                en_dim_pin;
    logic                sync_pin;
    logic                undervoltage_lockout;
    logic                freq_set_pin;
    logic                freq_clamp_req;
    logic                gate_ready;
    logic [`LDS_NCH-1:0] led_above_120mv;
    logic [`LDS_NCH-1:0] led_below_70mv;
    logic [`LDS_NCH-1:0] led_above_325mv;
    logic                led_voltage_ok;
    logic                osc_tick;
    logic                disconnect_on;
    logic                boost_enable;
    logic [`LDS_NCH-1:0] sink_enable;
    logic [`LDS_NCH-1:0] channel_in_loop;
    logic                softstart_sink_current;
    logic                softstart_switch_limit;
    logic                full_switch_limit;
    logic                use_sync_clock;
    logic                freq_clamp;
    logic                low_power;
    lds_state_e          state;
    logic [1:0]          used;
    int                  fails;
    int                  cmp_count;
    int                  n;

    lds_sequencer DUT (.*);
    lds_host_model host (.*);

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Oscillator tick every second cycle
    always @(posedge core_clk) osc_tick <= sys_rst ? 1'b0 : ~osc_tick;

    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // Bounded wait; n holds the cycles spent
    task automatic wait_st(lds_state_e s, int bound);
        n = 0;
        while (state !== s && n < bound) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("state", 32'(s), 32'(state));
        if (state !== s) give_verdict();
    endtask

    task automatic cyc(int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // Comparator levels for shorted and in-use channels
    task automatic set_pins(logic [1:0] sh, logic [1:0] inuse);
        @(posedge core_clk);
        led_below_70mv  <= sh;
        led_above_120mv <= ~sh;
        led_above_325mv <= inuse & ~sh;
    endtask

    initial begin
        sys_rst = 1'b1;
        en_req = 1'b0;
        sync_run = 1'b0;
        sync_half = 4'h4;
        undervoltage_lockout = 1'b1;
        freq_set_pin = 1'b0;
        freq_clamp_req = 1'b0;
        gate_ready = 1'b0;
        led_above_120mv = 2'h0;
        led_below_70mv = 2'h0;
        led_above_325mv = 2'h0;
        led_voltage_ok = 1'b0;
        fails = 0;
        cmp_count = 0;
        void'($urandom(7092));
        used = {1'($urandom_range(1, 0)), 1'b1};
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        en_req <= 1'b1;
        cyc(40);
        check("low_power", 1, low_power);
        check("state", 32'(LDS_OFF), 32'(state));
        @(posedge core_clk);
        undervoltage_lockout <= 1'b0;
        wait_st(LDS_WAIT_FREQ, 60);
        cyc(40);
        check("state", 32'(LDS_WAIT_FREQ), 32'(state));
        @(posedge core_clk);
        freq_set_pin <= 1'b1;
        wait_st(LDS_GATE_RAMP, 20);
        cyc(30);
        check("state", 32'(LDS_GATE_RAMP), 32'(state));
        check("disconnect_on", 1, disconnect_on);
        set_pins(2'b01, used);
        gate_ready <= 1'b1;
        wait_st(LDS_DETECT, 20);
        wait_st(LDS_SHORT_HOLD, 8200);
        check("short_delay", 1, n >= 5990);
        cyc(200);
        check("state", 32'(LDS_SHORT_HOLD), 32'(state));
        check("sink_enable", 0, sink_enable);
        set_pins(2'b00, used);
        wait_st(LDS_DETECT, 40);
        wait_st(LDS_SOFT_START, 8200);
        check("detect_delay", 1, n >= 5990 && n <= 8050);
        cyc(3);
        check("ss_mode", 3'b110, {softstart_sink_current,
              softstart_switch_limit, full_switch_limit});
        check("sink_enable", used, sink_enable);
        check("channel_in_loop", used, channel_in_loop);
        check("boost_enable", 1, boost_enable);
        @(posedge core_clk);
        led_voltage_ok <= 1'b1;
        wait_st(LDS_RUN, 20);
        cyc(3);
        check("run_mode", 3'b001, {softstart_sink_current,
              softstart_switch_limit, full_switch_limit});
        @(posedge core_clk);
        freq_clamp_req <= 1'b1;
        cyc(5);
        check("freq_clamp", 1, freq_clamp);
        @(posedge core_clk);
        freq_clamp_req <= 1'b0;
        cyc(5);
        check("freq_clamp", 0, freq_clamp);
        // Sync must be running before the freq pin drops, else it is a short
        @(posedge core_clk);
        sync_half <= 4'($urandom_range(6, 3));
        sync_run <= 1'b1;
        cyc(100);
        check("use_sync_clock", 1, use_sync_clock);
        @(posedge core_clk);
        freq_set_pin <= 1'b0;
        cyc(60);
        check("sink_enable", used, sink_enable);
        check("boost_enable", 1, boost_enable);
        check("state", 32'(LDS_RUN), 32'(state));
        @(posedge core_clk);
        sync_run <= 1'b0;
        wait_st(LDS_SHUTDOWN, 250);
        check("loss_delay", 1, n >= 120);
        cyc(2);
        check("stage_off", 0, {boost_enable, disconnect_on,
              sink_enable});
        cyc(200);
        check("state", 32'(LDS_SHUTDOWN), 32'(state));
        @(posedge core_clk);
        freq_set_pin <= 1'b1;
        wait_st(LDS_SOFT_START, 150);
        wait_st(LDS_RUN, 20);
        cyc(3);
        check("use_sync_clock", 0, use_sync_clock);
        @(posedge core_clk);
        freq_set_pin <= 1'b0;
        wait_st(LDS_SHUTDOWN, 20);
        cyc(2);
        check("short_off", 0, {boost_enable, disconnect_on,
              sink_enable});
        @(posedge core_clk);
        freq_set_pin <= 1'b1;
        wait_st(LDS_SOFT_START, 150);
        wait_st(LDS_RUN, 20);
        cyc(3);
        @(posedge core_clk);
        en_req <= 1'b0;
        cyc(8);
        check("dim_off", 0, {boost_enable, sink_enable});
        check("state", 32'(LDS_RUN), 32'(state));
        wait_st(LDS_SHUTDOWN, 66000);
        check("dim_timeout", 1, n >= 65000);
        @(posedge core_clk);
        en_req <= 1'b1;
        undervoltage_lockout <= 1'b1;
        wait_st(LDS_OFF, 20);
        cyc(2);
        check("disconnect_on", 0, disconnect_on);
        give_verdict();
    end
endmodule
